// ---- hw/swr_pkg.sv ----
// Constants, register map and types for the supervision watchdog and reset block
package swr_pkg;

	// Clock is 200 MHz
	localparam longint unsigned CLK_PERIOD_NS = 64'd5;

	// Times as specified, in microseconds
	localparam longint unsigned T_RST_PULSE_US = 64'd1000;
	localparam longint unsigned T_MS_TICK_US = 64'd1000;
	localparam longint unsigned T_STARTUP_PERIOD_US = 64'd320000;
	localparam longint unsigned T_STARTUP_LOW_US = 64'd2500;
	localparam longint unsigned T_WINDOW_BASE_US = 64'd2500;
	localparam longint unsigned T_WAKE_BASE_US = 64'd80000;
	localparam longint unsigned T_RETRY_US = 64'd1000000;

	// Least times, rounded up to whole cycles
	localparam longint unsigned RST_PULSE_CYC = (T_RST_PULSE_US * 64'd1000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
	localparam longint unsigned MS_TICK_CYC = (T_MS_TICK_US * 64'd1000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
	localparam longint unsigned STARTUP_PERIOD_CYC = (T_STARTUP_PERIOD_US * 64'd1000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
	localparam longint unsigned STARTUP_LOW_CYC = (T_STARTUP_LOW_US * 64'd1000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
	localparam longint unsigned WINDOW_BASE_CYC = (T_WINDOW_BASE_US * 64'd1000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
	localparam longint unsigned WAKE_BASE_CYC = (T_WAKE_BASE_US * 64'd1000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
	localparam longint unsigned RETRY_CYC = (T_RETRY_US * 64'd1000 + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;

	// Timer width: longest wake interval is 80 ms shifted by 15
	localparam int CW = 40;
	localparam logic [2:0] STARTUP_TRIES = 3'h7;

	// Register bus
	localparam int AW = 4;
	localparam int DW = 16;
	localparam logic [AW-1:0] ADDR_REGULATOR_CTRL = 4'h0;
	localparam logic [AW-1:0] ADDR_WATCHDOG_CFG = 4'h1;
	localparam logic [AW-1:0] ADDR_OSC_TRIM = 4'h2;
	localparam logic [AW-1:0] ADDR_STATUS = 4'h3;
	localparam logic [AW-1:0] ADDR_WAKE_SRC = 4'h4;

	// regulator_control_reg fields
	localparam int RC_SLEEP_BIT = 0;
	localparam int RC_PERIPH_BIT = 1;
	localparam int RC_XCVR_BIT = 2;
	localparam int RC_UVSEL_BIT = 3;
	localparam int RC_STBY_BIT = 4;
	localparam int RC_IDF_BIT = 5;
	// watchdog_config_reg fields
	localparam int WC_WAKE_LSB = 0;
	localparam int WC_WIN_LSB = 4;
	localparam int WC_EN_BIT = 6;
	// status fields
	localparam int ST_THERM_LSB = 0;
	localparam int ST_WAKE_BIT = 3;
	localparam int ST_WINERR_BIT = 4;
	localparam int ST_ACKED_BIT = 5;
	localparam int ST_MODE_LSB = 6;
	localparam int ST_TRIES_LSB = 8;
	// wake source fields
	localparam int WS_EXT_BIT = 0;
	localparam int WS_TMR_BIT = 1;

	// Reset values and trim limits
	localparam logic [3:0] WAKE_SEL_RST = 4'h0;
	localparam logic [1:0] WIN_SEL_RST = 2'h0;
	localparam logic WD_EN_RST = 1'h1;
	localparam logic signed [5:0] TRIM_RST = 6'sh00;
	localparam logic signed [5:0] TRIM_MAX = 6'sh10;
	localparam logic signed [5:0] TRIM_MIN = 6'sh30;

	typedef enum logic [1:0] {
		MODE_STARTUP = 2'b00,
		MODE_WINDOW = 2'b01,
		MODE_SLEEP = 2'b10,
		MODE_WAKE_UV = 2'b11
	} swr_mode_e;

endpackage : swr_pkg

// ---- hw/swr_cnt.sv ----
// Loadable down counter with zero flag
`timescale 1ns/1ps
`default_nettype none
module swr_cnt #(
	parameter int W = 40,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic run,
	output logic [W-1:0] count,
	output logic done
);
	typedef struct packed {
		logic [W-1:0] value;
	} swr_cnt_s;

	swr_cnt_s cnt_reg;
	swr_cnt_s cnt_next;

	always_comb begin
		cnt_next = cnt_reg;
		if (load) begin
			cnt_next.value = load_val;
		end else if (run && cnt_reg.value != '0) begin
			cnt_next.value = cnt_reg.value - W'(1);
		end
	end

	always_ff @(posedge clk) begin
		if (sys_rst) begin
			cnt_reg.value <= INIT;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	assign count = cnt_reg.value;
	assign done = (cnt_reg.value == '0);
endmodule : swr_cnt
`default_nettype wire

// ---- hw/swr_supervisor.sv ----
// Watchdog, reset generation and sleep supervision of the regulator chip
// What this block does
// - Sleep: slow oscillator with watchdog or armed wake timer, else stopped
// - Standby and operation: fast oscillator, trimmable +-16%
// - Wake timer raises wakeup after programmed interval
// - Startup: 2.5 ms reset pulse every 320 ms
// - Seven unanswered startup periods force sleep
// - Host acknowledges inside programmable window
// - Missed or early acknowledge restarts startup
// - Battery power-on gives the default state
// - Host rail undervoltage asserts reset, keeps configuration
// - Internal reset pulse lasts 1 ms
// - Millisecond undervoltage sampling extends reset
// - Sleep request disables rails, no undervoltage reset
// - Wakeup with good rail resumes without reset after a requested sleep with startup acknowledged, else startup
// - Wakeup with low rail holds reset, then startup
// - External low on reset pin means host failure
// - Thermal warnings set flags and interrupt
// - Thermal shutdown switches off rails by level
// - Host rail returns on wakeup; 1 s retry after thermal shutdown when no wake source is configured
// - Low-current standby only after startup acknowledged
`timescale 1ns/1ps
`default_nettype none
module swr_supervisor #(
	parameter longint unsigned RST_PULSE_CYC = swr_pkg::RST_PULSE_CYC,
	parameter longint unsigned MS_TICK_CYC = swr_pkg::MS_TICK_CYC,
	parameter longint unsigned STARTUP_PERIOD_CYC = swr_pkg::STARTUP_PERIOD_CYC,
	parameter longint unsigned STARTUP_LOW_CYC = swr_pkg::STARTUP_LOW_CYC,
	parameter longint unsigned WINDOW_BASE_CYC = swr_pkg::WINDOW_BASE_CYC,
	parameter longint unsigned WAKE_BASE_CYC = swr_pkg::WAKE_BASE_CYC,
	parameter longint unsigned RETRY_CYC = swr_pkg::RETRY_CYC
) (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic battery_supply_ok,
	input wire logic host_rail_uv,
	input wire logic frame_ok,
	input wire logic wake_in,
	input wire logic [2:0] therm_warn,
	input wire logic therm_shut_mid,
	input wire logic therm_shut_high,
	input wire logic reset_out_n_i,
	output logic reset_out_n_o,
	output logic reset_out_n_oe_n,
	output logic interrupt_out_n,
	output logic host_supply_rail_en,
	output logic peripheral_supply_rail_en,
	output logic transceiver_supply_rail_en,
	output logic uv_thresh_low,
	output logic can_standby,
	output logic id_filter_en,
	output logic standby_low_current,
	output logic osc_run,
	output logic osc_slow,
	output logic [5:0] osc_trim,
	input wire logic [swr_pkg::AW-1:0] reg_addr,
	input wire logic [swr_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [swr_pkg::DW-1:0] reg_rdata
);
	localparam int CW = swr_pkg::CW;

	typedef struct packed {
		swr_pkg::swr_mode_e mode;
		logic [2:0] tries;
		logic acked;
		logic forced_sleep;
		logic therm_sleep;
		logic ext_hold;
		logic wake_armed;
		logic periph_en;
		logic xcvr_en;
		logic uv_sel;
		logic standby_req;
		logic idf_en;
		logic [3:0] wake_sel;
		logic [1:0] win_sel;
		logic wd_en;
		logic [5:0] trim;
		logic wake_ext_en;
		logic wake_tmr_en;
		logic [2:0] therm_flag;
		logic wake_flag;
		logic win_err;
		logic pin_prev;
		logic [swr_pkg::DW-1:0] rdata;
		logic rst_oe_n;
		logic int_n;
		logic host_en;
		logic periph_out;
		logic xcvr_out;
		logic can_stby;
		logic stby_lp;
		logic osc_on;
		logic osc_lo;
	} swr_state_s;

	swr_state_s state_reg;
	swr_state_s state_next;

	logic por;
	logic ph_ld;
	logic [CW-1:0] ph_val;
	logic [CW-1:0] ph_cnt;
	logic ph_done;
	logic pl_ld;
	logic [CW-1:0] pl_cnt;
	logic pl_done;
	logic ms_done;
	logic wk_ld;
	logic [CW-1:0] wk_val;
	logic [CW-1:0] wk_cnt;
	logic wk_done;
	logic wk_run;

	// Battery below power-on level holds everything in the default state
	assign por = sys_rst | ~battery_supply_ok;

	// Startup period and acknowledge window share one timer
	swr_cnt #(
		.W(CW),
		.INIT(CW'(STARTUP_PERIOD_CYC - 64'd1))
	) u_phase (
		.clk(clk),
		.sys_rst(por),
		.load(ph_ld),
		.load_val(ph_val),
		.run(1'b1),
		.count(ph_cnt),
		.done(ph_done)
	);

	swr_cnt #(
		.W(CW),
		.INIT('0)
	) u_pulse (
		.clk(clk),
		.sys_rst(por),
		.load(pl_ld),
		.load_val(CW'(RST_PULSE_CYC)),
		.run(1'b1),
		.count(pl_cnt),
		.done(pl_done)
	);

	// Free running 1 ms sampling tick
	swr_cnt #(
		.W(CW),
		.INIT('0)
	) u_ms (
		.clk(clk),
		.sys_rst(por),
		.load(ms_done),
		.load_val(CW'(MS_TICK_CYC - 64'd1)),
		.run(1'b1),
		.count(),
		.done(ms_done)
	);

	swr_cnt #(
		.W(CW),
		.INIT('0)
	) u_wake (
		.clk(clk),
		.sys_rst(por),
		.load(wk_ld),
		.load_val(wk_val),
		.run(wk_run),
		.count(wk_cnt),
		.done(wk_done)
	);

	always_comb begin
		logic sleeping;
		logic low_phase;
		logic [CW-1:0] win_len;
		logic win_open;
		logic wd_fail;
		logic pin_fall;
		logic sleep_req;
		logic enter_sleep;
		logic wake;
		logic stby_active;
		logic drive;
		logic signed [5:0] trim_w;
		state_next = state_reg;
		sleeping = (state_reg.mode == swr_pkg::MODE_SLEEP);
		ph_ld = 1'b0;
		ph_val = CW'(STARTUP_PERIOD_CYC - 64'd1);
		pl_ld = 1'b0;
		wk_ld = 1'b0;
		wk_val = CW'(WAKE_BASE_CYC) << state_reg.wake_sel;
		// Intervals are counted in clock cycles only
		wk_run = state_reg.wd_en | state_reg.therm_sleep;
		win_len = CW'(WINDOW_BASE_CYC) << state_reg.win_sel;
		// Reset low during the first part of each startup period
		low_phase = (state_reg.mode == swr_pkg::MODE_STARTUP) &&
			(ph_cnt > CW'(STARTUP_PERIOD_CYC - 64'd1 - STARTUP_LOW_CYC));
		// Timer counts 2T-1 down to 0; window is open for its second half
		win_open = (ph_cnt < win_len);
		wd_fail = 1'b0;
		sleep_req = reg_wr && reg_addr == swr_pkg::ADDR_REGULATOR_CTRL &&
			reg_wdata[swr_pkg::RC_SLEEP_BIT];
		enter_sleep = 1'b0;
		// Only a falling edge counts, so a slow external capacitor does not retrigger
		pin_fall = state_reg.pin_prev && !reset_out_n_i && state_reg.rst_oe_n;
		wake = sleeping && ((wake_in && state_reg.wake_ext_en) ||
			(wk_done && state_reg.wake_armed));
		stby_active = state_reg.standby_req && state_reg.acked &&
			state_reg.mode == swr_pkg::MODE_WINDOW;
		trim_w = $signed(reg_wdata[5:0]);
		state_next.pin_prev = reset_out_n_i;
		state_next.rdata = '0;

		if (reg_wr) begin
			unique case (reg_addr)
				swr_pkg::ADDR_REGULATOR_CTRL: begin
					state_next.periph_en = reg_wdata[swr_pkg::RC_PERIPH_BIT];
					state_next.xcvr_en = reg_wdata[swr_pkg::RC_XCVR_BIT];
					state_next.uv_sel = reg_wdata[swr_pkg::RC_UVSEL_BIT];
					state_next.standby_req = reg_wdata[swr_pkg::RC_STBY_BIT];
					state_next.idf_en = reg_wdata[swr_pkg::RC_IDF_BIT];
				end
				swr_pkg::ADDR_WATCHDOG_CFG: begin
					state_next.wake_sel = reg_wdata[swr_pkg::WC_WAKE_LSB +: 4];
					state_next.win_sel = reg_wdata[swr_pkg::WC_WIN_LSB +: 2];
					state_next.wd_en = reg_wdata[swr_pkg::WC_EN_BIT];
				end
				swr_pkg::ADDR_OSC_TRIM: begin
					// Trim is clamped to the supported span
					if (trim_w > swr_pkg::TRIM_MAX) begin
						state_next.trim = swr_pkg::TRIM_MAX;
					end else if (trim_w < swr_pkg::TRIM_MIN) begin
						state_next.trim = swr_pkg::TRIM_MIN;
					end else begin
						state_next.trim = trim_w;
					end
				end
				swr_pkg::ADDR_STATUS: begin
					state_next.therm_flag = state_reg.therm_flag &
						~reg_wdata[swr_pkg::ST_THERM_LSB +: 3];
					state_next.wake_flag = state_reg.wake_flag &
						~reg_wdata[swr_pkg::ST_WAKE_BIT];
					state_next.win_err = state_reg.win_err &
						~reg_wdata[swr_pkg::ST_WINERR_BIT];
				end
				swr_pkg::ADDR_WAKE_SRC: begin
					state_next.wake_ext_en = reg_wdata[swr_pkg::WS_EXT_BIT];
					state_next.wake_tmr_en = reg_wdata[swr_pkg::WS_TMR_BIT];
				end
				default: begin
				end
			endcase
		end

		if (reg_rd) begin
			unique case (reg_addr)
				swr_pkg::ADDR_REGULATOR_CTRL: begin
					state_next.rdata[swr_pkg::RC_PERIPH_BIT] = state_reg.periph_en;
					state_next.rdata[swr_pkg::RC_XCVR_BIT] = state_reg.xcvr_en;
					state_next.rdata[swr_pkg::RC_UVSEL_BIT] = state_reg.uv_sel;
					state_next.rdata[swr_pkg::RC_STBY_BIT] = state_reg.standby_req;
					state_next.rdata[swr_pkg::RC_IDF_BIT] = state_reg.idf_en;
				end
				swr_pkg::ADDR_WATCHDOG_CFG: begin
					state_next.rdata[swr_pkg::WC_WAKE_LSB +: 4] = state_reg.wake_sel;
					state_next.rdata[swr_pkg::WC_WIN_LSB +: 2] = state_reg.win_sel;
					state_next.rdata[swr_pkg::WC_EN_BIT] = state_reg.wd_en;
				end
				swr_pkg::ADDR_OSC_TRIM: begin
					state_next.rdata[5:0] = state_reg.trim;
				end
				swr_pkg::ADDR_STATUS: begin
					state_next.rdata[swr_pkg::ST_THERM_LSB +: 3] = state_reg.therm_flag;
					state_next.rdata[swr_pkg::ST_WAKE_BIT] = state_reg.wake_flag;
					state_next.rdata[swr_pkg::ST_WINERR_BIT] = state_reg.win_err;
					state_next.rdata[swr_pkg::ST_ACKED_BIT] = state_reg.acked;
					state_next.rdata[swr_pkg::ST_MODE_LSB +: 2] = state_reg.mode;
					state_next.rdata[swr_pkg::ST_TRIES_LSB +: 3] = state_reg.tries;
				end
				swr_pkg::ADDR_WAKE_SRC: begin
					state_next.rdata[swr_pkg::WS_EXT_BIT] = state_reg.wake_ext_en;
					state_next.rdata[swr_pkg::WS_TMR_BIT] = state_reg.wake_tmr_en;
				end
				default: begin
				end
			endcase
		end

		// Hardware sets win over software clears
		state_next.therm_flag = state_next.therm_flag | therm_warn;

		// Wake timer in standby raises a wake condition each interval
		if (stby_active && state_reg.wake_tmr_en) begin
			if (wk_done) begin
				wk_ld = 1'b1;
				state_next.wake_armed = 1'b1;
				if (state_reg.wake_armed) begin
					state_next.wake_flag = 1'b1;
				end
			end
		end else if (!sleeping) begin
			state_next.wake_armed = 1'b0;
		end

		unique case (state_reg.mode)
			swr_pkg::MODE_STARTUP: begin
				if (frame_ok) begin
					state_next.mode = swr_pkg::MODE_WINDOW;
					state_next.acked = 1'b1;
					state_next.tries = '0;
					ph_ld = 1'b1;
					ph_val = (win_len << 1) - CW'(1);
				end else if (ph_done) begin
					if (state_reg.tries == swr_pkg::STARTUP_TRIES - 3'h1) begin
						enter_sleep = 1'b1;
						state_next.forced_sleep = 1'b1;
					end else begin
						state_next.tries = state_reg.tries + 3'h1;
						ph_ld = 1'b1;
					end
				end
			end
			swr_pkg::MODE_WINDOW: begin
				if (frame_ok) begin
					if (win_open) begin
						ph_ld = 1'b1;
						ph_val = (win_len << 1) - CW'(1);
					end else begin
						wd_fail = 1'b1;
					end
				end else if (ph_done) begin
					wd_fail = 1'b1;
				end
			end
			swr_pkg::MODE_SLEEP: begin
				if (wake) begin
					state_next.ext_hold = 1'b0;
					state_next.wake_armed = 1'b0;
					state_next.forced_sleep = 1'b0;
					state_next.therm_sleep = 1'b0;
					state_next.tries = '0;
					ph_ld = 1'b1;
					if (host_rail_uv) begin
						state_next.mode = swr_pkg::MODE_WAKE_UV;
					end else if (state_reg.forced_sleep || state_reg.therm_sleep ||
						!state_reg.acked) begin
						state_next.mode = swr_pkg::MODE_STARTUP;
					end else begin
						state_next.mode = swr_pkg::MODE_WINDOW;
						ph_val = (win_len << 1) - CW'(1);
					end
				end
			end
			swr_pkg::MODE_WAKE_UV: begin
				ph_ld = 1'b1;
				if (!host_rail_uv) begin
					state_next.mode = swr_pkg::MODE_STARTUP;
				end
			end
		endcase

		// External low on the pin: pulse or hold until wakeup
		if (pin_fall) begin
			if (state_reg.wd_en) begin
				pl_ld = 1'b1;
			end else begin
				state_next.ext_hold = 1'b1;
			end
			if (state_reg.mode == swr_pkg::MODE_WINDOW) begin
				wd_fail = 1'b1;
			end
		end

		if (wd_fail) begin
			state_next.mode = swr_pkg::MODE_STARTUP;
			state_next.tries = '0;
			state_next.acked = 1'b0;
			state_next.win_err = 1'b1;
			ph_ld = 1'b1;
			ph_val = CW'(STARTUP_PERIOD_CYC - 64'd1);
		end

		// Rail sampled each millisecond stretches the pulse by up to 1 ms
		if (ms_done && host_rail_uv && !sleeping) begin
			pl_ld = 1'b1;
		end

		if (therm_shut_mid) begin
			state_next.periph_en = 1'b0;
			state_next.xcvr_en = 1'b0;
		end

		if (sleep_req && state_reg.mode != swr_pkg::MODE_WAKE_UV) begin
			enter_sleep = 1'b1;
		end

		if (therm_shut_high && !sleeping) begin
			enter_sleep = 1'b1;
			state_next.therm_sleep = 1'b1;
		end

		if (enter_sleep) begin
			state_next.mode = swr_pkg::MODE_SLEEP;
			state_next.wake_armed = 1'b0;
			if (state_reg.wake_tmr_en && state_reg.wd_en) begin
				wk_ld = 1'b1;
				state_next.wake_armed = 1'b1;
			end else if (therm_shut_high && !state_reg.wake_ext_en) begin
				// No wake source configured: arm a retry so the host rail returns
				wk_ld = 1'b1;
				wk_val = CW'(RETRY_CYC);
				state_next.wake_armed = 1'b1;
			end
		end

		// Undervoltage reset is not generated while asleep
		drive = !pl_done || low_phase || (host_rail_uv && !sleeping) ||
			state_reg.mode == swr_pkg::MODE_WAKE_UV || state_reg.ext_hold;
		state_next.rst_oe_n = !drive;
		state_next.int_n = !(|state_next.therm_flag);
		state_next.host_en = state_next.mode != swr_pkg::MODE_SLEEP;
		state_next.periph_out = state_next.periph_en &&
			state_next.mode != swr_pkg::MODE_SLEEP;
		state_next.xcvr_out = state_next.xcvr_en && state_next.mode != swr_pkg::MODE_SLEEP;
		state_next.can_stby = !state_next.xcvr_out;
		state_next.stby_lp = stby_active;
		// Oscillator stops in sleep unless a timer needs it
		state_next.osc_lo = (state_next.mode == swr_pkg::MODE_SLEEP) &&
			(state_next.wd_en || state_next.wake_armed);
		state_next.osc_on = (state_next.mode != swr_pkg::MODE_SLEEP) ||
			state_next.osc_lo;
	end

	always_ff @(posedge clk) begin
		if (por) begin
			state_reg <= '0;
			state_reg.mode <= swr_pkg::MODE_STARTUP;
			state_reg.wake_sel <= swr_pkg::WAKE_SEL_RST;
			state_reg.win_sel <= swr_pkg::WIN_SEL_RST;
			state_reg.wd_en <= swr_pkg::WD_EN_RST;
			state_reg.trim <= swr_pkg::TRIM_RST;
			state_reg.pin_prev <= 1'b1;
			state_reg.rst_oe_n <= 1'b1;
			state_reg.int_n <= 1'b1;
			state_reg.host_en <= 1'b1;
			state_reg.can_stby <= 1'b1;
			state_reg.osc_on <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// Pin level is always low; only the enable moves it
	assign reset_out_n_o = 1'b0;
	assign reset_out_n_oe_n = state_reg.rst_oe_n;
	assign interrupt_out_n = state_reg.int_n;
	assign host_supply_rail_en = state_reg.host_en;
	assign peripheral_supply_rail_en = state_reg.periph_out;
	assign transceiver_supply_rail_en = state_reg.xcvr_out;
	assign uv_thresh_low = state_reg.uv_sel;
	assign can_standby = state_reg.can_stby;
	assign id_filter_en = state_reg.idf_en;
	assign standby_low_current = state_reg.stby_lp;
	assign osc_run = state_reg.osc_on;
	assign osc_slow = state_reg.osc_lo;
	assign osc_trim = state_reg.trim;
	assign reg_rdata = state_reg.rdata;
endmodule : swr_supervisor
`default_nettype wire

// ---- tb/swr_supervisor_chk.sv ----
// Port assertions for the supervision watchdog block
`timescale 1ns/1ps
`default_nettype none
module swr_supervisor_chk (
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic host_rail_uv,
	input wire logic [2:0] therm_warn,
	input wire logic therm_shut_mid,
	input wire logic therm_shut_high,
	input wire logic reset_out_n_i,
	input wire logic reset_out_n_o,
	input wire logic reset_out_n_oe_n,
	input wire logic interrupt_out_n,
	input wire logic host_supply_rail_en,
	input wire logic peripheral_supply_rail_en,
	input wire logic transceiver_supply_rail_en,
	input wire logic can_standby,
	input wire logic id_filter_en,
	input wire logic osc_run,
	input wire logic osc_slow,
	input wire logic [5:0] osc_trim
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	sequence s_pin_held;
		!reset_out_n_oe_n [*8];
	endsequence
	sequence s_ext_fall;
		$fell(reset_out_n_i) && reset_out_n_oe_n;
	endsequence
	a_od_low: assert property (reset_out_n_o == 1'b0)
		else $error("reset pin driven high");
	a_por_state: assert property ($fell(sys_rst) |-> host_supply_rail_en && can_standby
		&& !peripheral_supply_rail_en && !transceiver_supply_rail_en && !id_filter_en)
		else $error("wrong power-on state");
	a_startup_low: assert property ($fell(sys_rst) |-> ##2 s_pin_held)
		else $error("no startup pulse");
	a_ext_pulse: assert property (s_ext_fall |-> ##[1:3] s_pin_held)
		else $error("pin failure not stretched");
	a_uv_reset: assert property ((host_rail_uv && host_supply_rail_en) [*2] |=>
		!reset_out_n_oe_n)
		else $error("no undervoltage reset");
	a_uv_release: assert property ($fell(host_rail_uv) && host_supply_rail_en
		|-> ##[1:48] reset_out_n_oe_n)
		else $error("undervoltage reset stuck");
	a_therm_int: assert property (|therm_warn |-> ##[1:2] !interrupt_out_n)
		else $error("no thermal interrupt");
	a_shut_mid: assert property (therm_shut_mid |=>
		!peripheral_supply_rail_en && !transceiver_supply_rail_en)
		else $error("rails on at shutdown");
	a_shut_high: assert property (therm_shut_high |-> ##[1:3] !host_supply_rail_en)
		else $error("host rail on at shutdown");
	a_trim_range: assert property ($signed(osc_trim) <= 16 && $signed(osc_trim) >= -16)
		else $error("trim out of range");
	a_slow_sleep: assert property (osc_slow |-> osc_run && !host_supply_rail_en)
		else $error("slow clock outside sleep");
endmodule : swr_supervisor_chk
`default_nettype wire

// ---- tb/swr_host_model.sv ----
// Host controller model: frame acknowledges and pulls on the reset pin
`timescale 1ns/1ps
`default_nettype none
module swr_host_model (
	input wire logic clk,
	input wire logic ack_req,
	input wire logic fail_req,
	output logic frame_ok,
	output logic pull_low
);
	logic fail_d = 1'b0;
	initial frame_ok = 1'b0;
	initial pull_low = 1'b0;
	// Only checksum-clean frames reach the device, as a one-cycle strobe
	always @(posedge clk) frame_ok <= ack_req;
	// Two-cycle pull stands in for a host failure pulling the reset pin low
	always @(posedge clk) begin
		fail_d <= fail_req;
		pull_low <= fail_req || fail_d;
	end
endmodule : swr_host_model
`default_nettype wire

// ---- tb/test_swr_supervisor.sv ----
// Self-checking bench for the supervision watchdog block
`timescale 1ns/1ps
`default_nettype none
module test_swr_supervisor;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic battery_supply_ok = 1'b1;
	logic host_rail_uv = 1'b0;
	logic wake_in = 1'b0;
	logic [2:0] therm_warn = 3'h0;
	logic therm_shut_mid = 1'b0;
	logic therm_shut_high = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic ack_req = 1'b0;
	logic fail_req = 1'b0;
	logic frame_ok, pull_low, reset_out_n_i, reset_out_n_o, reset_out_n_oe_n, interrupt_out_n;
	logic host_supply_rail_en, peripheral_supply_rail_en, transceiver_supply_rail_en;
	logic uv_thresh_low, can_standby, id_filter_en, standby_low_current, osc_run, osc_slow;
	logic [5:0] osc_trim;
	logic [15:0] reg_rdata;
	int n_mismatch = 0;
	int cmp_count = 0;
	int i;
	int w;
	// Pull-up wins unless either side pulls low
	assign reset_out_n_i = (reset_out_n_oe_n !== 1'b0) && !pull_low;
	swr_supervisor #(.RST_PULSE_CYC(20), .MS_TICK_CYC(20), .STARTUP_PERIOD_CYC(200),
		.STARTUP_LOW_CYC(10), .WINDOW_BASE_CYC(16), .WAKE_BASE_CYC(50), .RETRY_CYC(100)) dut (
		.clk, .sys_rst, .battery_supply_ok, .host_rail_uv, .frame_ok, .wake_in, .therm_warn,
		.therm_shut_mid, .therm_shut_high, .reset_out_n_i, .reset_out_n_o, .reset_out_n_oe_n,
		.interrupt_out_n, .host_supply_rail_en, .peripheral_supply_rail_en,
		.transceiver_supply_rail_en, .uv_thresh_low, .can_standby, .id_filter_en,
		.standby_low_current, .osc_run, .osc_slow, .osc_trim, .reg_addr, .reg_wdata, .reg_wr,
		.reg_rd, .reg_rdata);
	swr_host_model host (.clk, .ack_req, .fail_req, .frame_ok, .pull_low);
	initial begin
		forever #2.5 clk = ~clk;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask : tick
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic done(input string s);
		$display("Test %s done", s);
	endtask : done
	// Counts cycles until the chosen output reaches v; a bound stops a hang
	task automatic waitfor(input bit rail, input logic v, input int b);
		w = 0;
		while (((rail ? host_supply_rail_en : reset_out_n_oe_n) !== v) && w < b) begin
			tick(1);
			w++;
		end
		if (w >= b) begin
			n_mismatch++;
			$display("FAIL at %0t: wait timed out", $time);
			final_report();
		end
	endtask : waitfor
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		tick(1);
		reg_wr <= 1'b0;
		tick(1);
	endtask : wr
	task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		tick(1);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata & m, e);
		tick(1);
	endtask : rdc
	task automatic ack();
		ack_req <= 1'b1;
		tick(1);
		ack_req <= 1'b0;
		tick(2);
	endtask : ack
	task automatic wake();
		wake_in <= 1'b1;
		tick(1);
		wake_in <= 1'b0;
		tick(3);
	endtask : wake
	initial begin
		tick(12);
		sys_rst <= 1'b0;
		tick(2);
		chk({host_supply_rail_en, peripheral_supply_rail_en, can_standby, id_filter_en}, 4'ha);
		rdc(swr_pkg::ADDR_WATCHDOG_CFG, 16'h007f, 16'h0040);
		rdc(4'hf, 16'hffff, 16'h0000);
		done("reset");
		waitfor(0, 1, 30);
		waitfor(0, 0, 250);
		for (i = 0; reset_out_n_oe_n === 1'b0 && i < 50; i++) tick(1);
		waitfor(0, 0, 250);
		chk(i >= 9 && i <= 11, 1);
		chk(i + w, 200);
		waitfor(1, 0, 1500);
		chk(w >= 980 && w <= 1020, 1);
		rdc(swr_pkg::ADDR_STATUS, 16'h00c0, 16'h0080);
		chk({osc_run, osc_slow}, 2'h3);
		done("startup");
		host_rail_uv <= 1'b1;
		tick(30);
		chk(reset_out_n_oe_n, 1);
		wr(swr_pkg::ADDR_WAKE_SRC, 16'h0001);
		wake();
		chk({host_supply_rail_en, reset_out_n_oe_n}, 2'h2);
		tick(40);
		chk(reset_out_n_oe_n, 0);
		host_rail_uv <= 1'b0;
		waitfor(0, 1, 60);
		rdc(swr_pkg::ADDR_STATUS, 16'h00c0, 16'h0000);
		wr(swr_pkg::ADDR_REGULATOR_CTRL, 16'h0010);
		chk(standby_low_current, 0);
		done("wake_uv");
		ack();
		rdc(swr_pkg::ADDR_STATUS, 16'h00e0, 16'h0060);
		wr(swr_pkg::ADDR_REGULATOR_CTRL, 16'h0010);
		tick(1);
		chk(standby_low_current, 1);
		tick(11);
		ack();
		rdc(swr_pkg::ADDR_STATUS, 16'h00d0, 16'h0040);
		ack();
		rdc(swr_pkg::ADDR_STATUS, 16'h00d0, 16'h0010);
		ack();
		tick(40);
		rdc(swr_pkg::ADDR_STATUS, 16'h00c0, 16'h0000);
		done("window");
		waitfor(0, 1, 40);
		ack();
		fail_req <= 1'b1;
		tick(1);
		fail_req <= 1'b0;
		tick(4);
		chk(reset_out_n_oe_n, 0);
		tick(12);
		chk(reset_out_n_oe_n, 0);
		rdc(swr_pkg::ADDR_STATUS, 16'h00c0, 16'h0000);
		waitfor(0, 1, 40);
		done("pin_fail");
		wr(swr_pkg::ADDR_WATCHDOG_CFG, 16'h0051);
		host_rail_uv <= 1'b1;
		tick(30);
		chk(reset_out_n_oe_n, 0);
		host_rail_uv <= 1'b0;
		waitfor(0, 1, 50);
		rdc(swr_pkg::ADDR_WATCHDOG_CFG, 16'h007f, 16'h0051);
		done("undervoltage");
		wr(swr_pkg::ADDR_REGULATOR_CTRL, 16'h0006);
		chk({peripheral_supply_rail_en, transceiver_supply_rail_en, can_standby}, 3'h6);
		for (i = 0; i < 3; i++) begin
			therm_warn <= 3'(1 << i);
			tick(1);
			therm_warn <= 3'h0;
			tick(3);
			chk(interrupt_out_n, 0);
			rdc(swr_pkg::ADDR_STATUS, 16'h0007, 16'(1 << i));
			wr(swr_pkg::ADDR_STATUS, 16'(1 << i));
			tick(1);
			chk(interrupt_out_n, 1);
		end
		therm_shut_mid <= 1'b1;
		tick(2);
		therm_shut_mid <= 1'b0;
		tick(2);
		chk({peripheral_supply_rail_en, transceiver_supply_rail_en}, 2'h0);
		wr(swr_pkg::ADDR_REGULATOR_CTRL, 16'h0006);
		chk({peripheral_supply_rail_en, transceiver_supply_rail_en}, 2'h3);
		done("thermal");
		ack();
		wr(swr_pkg::ADDR_REGULATOR_CTRL, 16'h0001);
		tick(1);
		chk(host_supply_rail_en, 0);
		wake();
		w = 0;
		for (i = 0; i < 30; i++) begin
			w += (reset_out_n_oe_n === 1'b0);
			tick(1);
		end
		chk({host_supply_rail_en, 16'(w)}, 17'h10000);
		rdc(swr_pkg::ADDR_STATUS, 16'h00c0, 16'h0040);
		wr(swr_pkg::ADDR_WAKE_SRC, 16'h0002);
		wr(swr_pkg::ADDR_REGULATOR_CTRL, 16'h0001);
		waitfor(1, 1, 300);
		chk(w >= 90 && w <= 110, 1);
		wr(swr_pkg::ADDR_WAKE_SRC, 16'h0000);
		therm_shut_high <= 1'b1;
		tick(1);
		therm_shut_high <= 1'b0;
		tick(4);
		chk(host_supply_rail_en, 0);
		waitfor(1, 1, 200);
		chk(w >= 90, 1);
		done("sleep");
		battery_supply_ok <= 1'b0;
		tick(3);
		battery_supply_ok <= 1'b1;
		tick(2);
		chk(reset_out_n_oe_n, 0);
		rdc(swr_pkg::ADDR_WATCHDOG_CFG, 16'h007f, 16'h0040);
		done("battery_por");
		final_report();
	end
endmodule : test_swr_supervisor
bind swr_supervisor swr_supervisor_chk chk (.clk, .sys_rst, .host_rail_uv, .therm_warn,
	.therm_shut_mid, .therm_shut_high, .reset_out_n_i, .reset_out_n_o, .reset_out_n_oe_n,
	.interrupt_out_n, .host_supply_rail_en, .peripheral_supply_rail_en,
	.transceiver_supply_rail_en, .can_standby, .id_filter_en, .osc_run, .osc_slow, .osc_trim);
`default_nettype wire
